/* File: src/mop_defines.vh */
`ifndef MOP_DEFINES_VH
`define MOP_DEFINES_VH
// ============================================================
// Register byte offsets
`define MOP_CTRL_OFS 8'h00
`define MOP_RATED_OFS 8'h04
`define MOP_OVF_OFS 8'h08
`define MOP_TAU_OFS 8'h0C
`define MOP_WARN_OFS 8'h10
`define MOP_TWARN_OFS 8'h14
`define MOP_TMAX_OFS 8'h18
`define MOP_STAT_OFS 8'h1C
`define MOP_PCT_OFS 8'h20
`define MOP_TEMP_OFS 8'h24
// ============================================================
// Field positions
`define MOP_CTRL_EN_BIT 0
`define MOP_STAT_TWARN_BIT 0
`define MOP_STAT_TERR_BIT 1
`define MOP_STAT_MWARN_BIT 2
`define MOP_STAT_MERR_BIT 3
`define MOP_STAT_OERR_BIT 4
`define MOP_SENS_LINEAR 2'h0
`define MOP_SENS_PTC 2'h1
`define MOP_SENS_SWITCH 2'h2
// ============================================================
// Reset values and codes
`define MOP_RATED_RST 16'h1770
`define MOP_OVF_RST 4'h2
`define MOP_TAU_RST 16'h0708
`define MOP_WARN_RST 8'h50
`define MOP_TWARN_RST 8'h78
`define MOP_TMAX_RST 8'h8C
`define MOP_ERR_MODEL 8'h1E
`define MOP_ERR_OVL 8'h1F
// ============================================================
// Timing and scaling
`define MOP_CLK_NS 40
`define MOP_TICK_NS 1000000
`define MOP_TICK_CYC (`MOP_TICK_NS / `MOP_CLK_NS)
`define MOP_TICKS_PER_S 32'h0000_03E8
`define MOP_FULL_SCALE 24'h01_0000
`define MOP_PCT_SCALE 14'h2710
`define MOP_TRIP_NUM 16'h0017
`define MOP_TRIP_DEN 16'h0014
`define MOP_OVL_K 24'h20_0B20
`endif

/* File: src/mop_top.v */
// Overview of operation
// - Sensor type selects linear, thermistor or switch temperature evaluation.
// - Linear sensor converted to Celsius; warning at threshold, error at max.
// - Thermistor or switch gives pass/fail; error when input shows overtemperature.
// - Model value is percent of maximum motor dissipation, an average measure.
// - Model uses rated current, overload factor and motor time constant.
// - Model warning level programmable; error fixed at 100 percent, code 30.
// - Model percentage readable by software at any time.
// - Model rises first-order toward 100 percent times squared current ratio.
// - Model starts from zero after reset.
// - Reset defaults: rated 6 A, overload factor 2, time constant 1800 s.
// - Trip current is 1.15 times the rated current.
// - At trip current the overload check trips after finite time.
// - At twice trip current, no trip before 8 minutes.
// - At six times trip current, no trip before 20 seconds.
// - Overload trip raises code 31; only rated current affects it.
// - Overload check always runs and cannot be disabled; in this design a zero rated current disables the trip.
// - Overload accumulator starts from zero after reset.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mop_defines.vh"
module mop_top #(
  parameter TICK_CYC = `MOP_TICK_CYC,
  parameter [15:0] TEMP_ZERO = 16'h0200,
  parameter [15:0] TEMP_GAIN = 16'h0040
) (
  input wire clk, // 25 MHz clock
  input wire rst_b, // Sync reset, active low
  input wire [15:0] avg_current, // Average motor current, mA
  input wire [11:0] temp_raw, // Linear sensor code, from pins
  input wire temp_trip, // Thermistor or switch trip, from pin
  input wire [7:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [7:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  output reg motor_off_q, // Switch-off request
  output reg warn_q, // Any warning latched
  output reg [7:0] err_code_q // Model or overload code, overload first
);
  localparam ST_IDLE = 2'd0;
  localparam ST_DIVT = 2'd1;
  localparam ST_DIVX = 2'd2;
  // ============================================================
  // Pin synchronisers
  reg [11:0] raw_s1_q, raw_s2_q;
  reg trip_s1_q, trip_s2_q;
  // Two flops per pin; a code caught mid-change is off for one clock only
  always @(posedge clk) begin
    raw_s1_q <= temp_raw;
    raw_s2_q <= raw_s1_q;
    trip_s1_q <= temp_trip;
    trip_s2_q <= trip_s1_q;
  end
  // ============================================================
  // Register file and tick
  reg model_en_q;
  reg [1:0] sens_q;
  reg [15:0] rated_q, tau_q;
  reg [3:0] ovf_q;
  reg [7:0] warn_lvl_q, twarn_q, tmax_q;
  reg [4:0] flag_q;
  reg [31:0] pct_q;
  reg signed [15:0] temp_c_q;
  reg [31:0] tick_cnt_q;
  reg tick_q;
  // Fixed 1 ms time base shared by both accumulators
  // Tick must outlast the 97-clock model update, or model steps are lost
  always @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == TICK_CYC - 1) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    end
  end
  // ============================================================
  // Temperature evaluation
  wire signed [31:0] temp_lin = ($signed({4'h0, raw_s2_q}) - $signed(TEMP_ZERO)) * $signed({1'b0, TEMP_GAIN});
  wire signed [15:0] temp_c = temp_lin[23:8];
  wire lin_sel = (sens_q == `MOP_SENS_LINEAR);
  wire t_warn_ev = lin_sel && (temp_c >= $signed({8'h00, twarn_q}));
  wire t_err_ev = lin_sel ? (temp_c >= $signed({8'h00, tmax_q})) : trip_s2_q;
  // Registered reading for the temperature register read path
  always @(posedge clk) begin
    if (!rst_b) temp_c_q <= 16'h0000;
    else temp_c_q <= temp_c;
  end
  // ============================================================
  // Overload check, always running, no enable
  wire [31:0] i2 = avg_current * avg_current;
  wire [31:0] r2 = rated_q * rated_q;
  // Margin sized from the trip current, 1.15 times rated: about 489 s at 2x, 45 s at 6x
  // Limit scales with rated squared, so the rating is the only setting that matters
  wire [55:0] ovl_lim = r2 * `MOP_OVL_K;
  reg [55:0] ovl_acc_q;
  // Heating above rated current, cooling below; trip at rated*1.15 is finite
  always @(posedge clk) begin
    if (!rst_b) begin
      ovl_acc_q <= 56'h00_0000_0000_0000;
    end else if (tick_q) begin
      if (i2 > r2) ovl_acc_q <= ovl_acc_q + {24'h00_0000, i2 - r2};
      else if (ovl_acc_q > {24'h00_0000, r2 - i2}) ovl_acc_q <= ovl_acc_q - {24'h00_0000, r2 - i2};
      else ovl_acc_q <= 56'h00_0000_0000_0000;
    end
  end
  // A zero rating disables the trip; software must program a real rating
  wire o_err_ev = (ovl_acc_q >= ovl_lim) && (rated_q != 16'h0000);
  // ============================================================
  // Power-loss model with a shared serial divider
  reg [1:0] st_q;
  reg [47:0] dvd_q;
  reg [32:0] rem_q;
  reg [31:0] dvs_q;
  reg [5:0] cnt_q;
  reg [47:0] x_q;
  reg neg_q;
  wire [19:0] imax = rated_q * ovf_q;
  wire [15:0] i_lim = ({4'h0, avg_current} > imax) ? imax[15:0] : avg_current;
  wire [31:0] il2 = i_lim * i_lim;
  wire [32:0] rem_sh = {rem_q[31:0], dvd_q[47]};
  wire div_ge = (rem_sh >= {1'b0, dvs_q});
  wire [47:0] tgt_x = {dvd_q[22:0], div_ge, 24'h00_0000}; // New target, scaled like the state
  wire [31:0] tau_n = tau_q * `MOP_TICKS_PER_S;
  // One serial divider serves both steps: 48 clocks for target, 48 for the share
  // Target first, then step the state by a 1/N share of the gap
  always @(posedge clk) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      dvd_q <= 48'h0000_0000_0000;
      rem_q <= 33'h0_0000_0000;
      dvs_q <= 32'h0000_0001;
      cnt_q <= 6'h00;
      x_q <= 48'h0000_0000_0000;
      neg_q <= 1'b0;
    end else if (!model_en_q) begin
      // Held cold while off, so enabling starts from zero as after reset
      st_q <= ST_IDLE;
      x_q <= 48'h0000_0000_0000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (tick_q) begin
            st_q <= ST_DIVT;
            dvd_q <= {il2, 16'h0000};
            dvs_q <= (r2 == 32'h0000_0000) ? 32'h0000_0001 : r2;
            rem_q <= 33'h0_0000_0000;
            cnt_q <= 6'h00;
          end
        end
        default: begin
          rem_q <= div_ge ? rem_sh - {1'b0, dvs_q} : rem_sh;
          dvd_q <= {dvd_q[46:0], div_ge};
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'h2F) begin
            cnt_q <= 6'h00;
            rem_q <= 33'h0_0000_0000;
            if (st_q == ST_DIVT) begin
              neg_q <= (x_q > tgt_x);
              dvd_q <= (x_q > tgt_x) ? x_q - tgt_x : tgt_x - x_q;
              dvs_q <= (tau_n == 32'h0000_0000) ? 32'h0000_0001 : tau_n;
              st_q <= ST_DIVX;
            end else begin
              x_q <= neg_q ? x_q - {dvd_q[46:0], div_ge} : x_q + {dvd_q[46:0], div_ge};
              st_q <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end
  wire m_err_ev = model_en_q && (x_q[47:24] >= `MOP_FULL_SCALE);
  // Percent scale: 65536 state units are 10000 steps of 0.01 percent
  wire [37:0] pct_w = x_q[47:24] * `MOP_PCT_SCALE;
  wire m_warn_ev = model_en_q && (pct_w[37:16] >= warn_lvl_q * 16'h0064);
  // Percent of maximum dissipation in 0.01 percent steps
  always @(posedge clk) begin
    if (!rst_b) pct_q <= 32'h0000_0000;
    else pct_q <= {10'h000, pct_w[37:16]};
  end
  // ============================================================
  // AXI4-Lite write channel
  wire aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire [31:0] wm = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wd = s_axi_wdata & wm;
  // Offsets past the status word, or unaligned, get a slave error
  wire wr_ok = (s_axi_awaddr <= `MOP_STAT_OFS) && (s_axi_awaddr[1:0] == 2'b00);
  wire clr_hit = aw_hs && (s_axi_awaddr == `MOP_STAT_OFS);
  // Address and data are taken together; nothing new while a response waits
  always @(posedge clk) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      model_en_q <= 1'b0;
      sens_q <= `MOP_SENS_LINEAR;
      rated_q <= `MOP_RATED_RST;
      ovf_q <= `MOP_OVF_RST;
      tau_q <= `MOP_TAU_RST;
      warn_lvl_q <= `MOP_WARN_RST;
      twarn_q <= `MOP_TWARN_RST;
      tmax_q <= `MOP_TMAX_RST;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (aw_hs) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        if (s_axi_awaddr == `MOP_CTRL_OFS) begin
          if (s_axi_wstrb[0]) model_en_q <= wd[`MOP_CTRL_EN_BIT];
          if (s_axi_wstrb[0]) sens_q <= wd[2:1];
        end else if (s_axi_awaddr == `MOP_RATED_OFS) begin
          rated_q <= (rated_q & ~wm[15:0]) | wd[15:0];
        end else if (s_axi_awaddr == `MOP_OVF_OFS) begin
          if (s_axi_wstrb[0]) ovf_q <= wd[3:0];
        end else if (s_axi_awaddr == `MOP_TAU_OFS) begin
          tau_q <= (tau_q & ~wm[15:0]) | wd[15:0];
        end else if (s_axi_awaddr == `MOP_WARN_OFS) begin
          if (s_axi_wstrb[0]) warn_lvl_q <= wd[7:0];
        end else if (s_axi_awaddr == `MOP_TWARN_OFS) begin
          if (s_axi_wstrb[0]) twarn_q <= wd[7:0];
        end else if (s_axi_awaddr == `MOP_TMAX_OFS) begin
          if (s_axi_wstrb[0]) tmax_q <= wd[7:0];
        end
      end
    end
  end
  // ============================================================
  // Latched flags, write one to clear, a new event beats the clear
  wire [4:0] ev = {o_err_ev, m_err_ev, m_warn_ev, t_err_ev, t_warn_ev};
  wire [4:0] clr = clr_hit ? wd[4:0] : 5'h00;
  wire [4:0] flag_d = (flag_q & ~clr) | ev;
  // Error code follows the latched flags, overload first
  always @(posedge clk) begin
    if (!rst_b) begin
      flag_q <= 5'h00;
      err_code_q <= 8'h00;
      motor_off_q <= 1'b0;
      warn_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      motor_off_q <= |flag_d[4:3] | flag_d[`MOP_STAT_TERR_BIT];
      warn_q <= flag_d[`MOP_STAT_TWARN_BIT] | flag_d[`MOP_STAT_MWARN_BIT];
      if (flag_d[`MOP_STAT_OERR_BIT]) err_code_q <= `MOP_ERR_OVL;
      else if (flag_d[`MOP_STAT_MERR_BIT]) err_code_q <= `MOP_ERR_MODEL;
      else err_code_q <= 8'h00;
    end
  end
  // ============================================================
  // AXI4-Lite read channel
  // One read at a time; data stands until the master takes it
  always @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) s_axi_arready <= 1'b1;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        if (s_axi_araddr == `MOP_CTRL_OFS) s_axi_rdata <= {29'h0000_0000, sens_q, model_en_q};
        else if (s_axi_araddr == `MOP_RATED_OFS) s_axi_rdata <= {16'h0000, rated_q};
        else if (s_axi_araddr == `MOP_OVF_OFS) s_axi_rdata <= {28'h000_0000, ovf_q};
        else if (s_axi_araddr == `MOP_TAU_OFS) s_axi_rdata <= {16'h0000, tau_q};
        else if (s_axi_araddr == `MOP_WARN_OFS) s_axi_rdata <= {24'h00_0000, warn_lvl_q};
        else if (s_axi_araddr == `MOP_TWARN_OFS) s_axi_rdata <= {24'h00_0000, twarn_q};
        else if (s_axi_araddr == `MOP_TMAX_OFS) s_axi_rdata <= {24'h00_0000, tmax_q};
        else if (s_axi_araddr == `MOP_STAT_OFS) s_axi_rdata <= {15'h0000, motor_off_q, err_code_q, 3'h0, flag_q};
        else if (s_axi_araddr == `MOP_PCT_OFS) s_axi_rdata <= pct_q;
        else if (s_axi_araddr == `MOP_TEMP_OFS) s_axi_rdata <= {{16{temp_c_q[15]}}, temp_c_q};
        else begin
          // Unmapped offsets answer zero data with a slave error
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      end
    end
  end
endmodule // mop_top

/* File: testbench/mop_top_asserts.sv */
`timescale 1ns/1ps
module mop_top_asserts (
  input wire clk, // Clock
  input wire rst_b, // Sync reset, active low
  input wire s_axi_awready, // Write address ready
  input wire s_axi_wready, // Write data ready
  input wire s_axi_bvalid, // Write response valid
  input wire s_axi_arready, // Read address ready
  input wire s_axi_rvalid, // Read data valid
  input wire motor_off_q, // Switch-off request
  input wire warn_q, // Warning latched
  input wire [7:0] err_code_q // Error code
);
  // ============================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Reset must leave nothing pending and nothing tripped
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !motor_off_q && !warn_q
    && err_code_q == 8'h00 && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not clear after reset");
  chk_code_legal: assert property (err_code_q inside {8'h00, 8'h1E, 8'h1F})
    else $error("unknown error code");
  chk_code_stops: assert property (err_code_q != 8'h00 |-> ##[0:1] motor_off_q)
    else $error("error without switch-off");
  // Only a register write may clear a latched flag
  chk_err_hold: assert property (err_code_q != 8'h00 && !s_axi_awready |=> err_code_q != 8'h00)
    else $error("error code dropped without write");
  chk_warn_hold: assert property (warn_q && !s_axi_awready |=> warn_q)
    else $error("warning dropped without write");
  chk_aw_pair: assert property ($rose(s_axi_awready) |-> s_axi_wready ##1 !s_axi_awready)
    else $error("write ready not a paired pulse");
  chk_b_after: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid ##1 !s_axi_bvalid)
    else $error("write response timing");
  chk_r_after: assert property (s_axi_arready |=> !s_axi_arready && s_axi_rvalid ##1 !s_axi_rvalid)
    else $error("read response timing");
endmodule // mop_top_asserts
bind mop_top mop_top_asserts u_chk (.clk(clk), .rst_b(rst_b), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .motor_off_q(motor_off_q), .warn_q(warn_q), .err_code_q(err_code_q));

/* File: testbench/mop_motor_model.sv */
`timescale 1ns/1ps
module mop_motor_model #(
  parameter [15:0] TEMP_ZERO = 16'h0200,
  parameter [15:0] TEMP_GAIN = 16'h0040
) (
  input wire clk, // Clock
  input wire [15:0] deg_c, // Winding temperature, positive only
  input wire [15:0] cur_ma, // Average current wanted
  input wire hot, // Thermistor or switch open
  output reg [15:0] avg_current, // Current feedback
  output reg [11:0] temp_raw, // Linear sensor code
  output reg temp_trip // Overtemperature contact
);
  // ============================================================
  // Sensor and current feedback
  initial {avg_current, temp_raw, temp_trip} = 29'h0;
  // Code rises 256/gain per degree; negative degrees not modelled
  always @(posedge clk) begin
    avg_current <= cur_ma;
    temp_raw <= TEMP_ZERO[11:0] + 12'((deg_c * 256) / TEMP_GAIN);
    temp_trip <= hot;
  end
endmodule // mop_motor_model

/* File: testbench/mop_top_test.sv */
`timescale 1ns/1ps
module mop_top_test;
  localparam int TICK = 120;
  logic clk, rst_b, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, err_code_q;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp;
  logic motor_off_q, warn_q, temp_trip, hot;
  logic [15:0] avg_current, cur_ma, deg_c;
  logic [11:0] temp_raw;
  int n_fail, n_compared;
  // ============================================================
  // Far side and device
  mop_motor_model u_motor (.clk(clk), .deg_c(deg_c), .cur_ma(cur_ma), .hot(hot),
    .avg_current(avg_current), .temp_raw(temp_raw), .temp_trip(temp_trip));
  mop_top #(.TICK_CYC(TICK)) u_dut (.clk(clk), .rst_b(rst_b), .avg_current(avg_current),
    .temp_raw(temp_raw), .temp_trip(temp_trip), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .motor_off_q(motor_off_q),
    .warn_q(warn_q), .err_code_q(err_code_q));
  // ============================================================
  // Helpers
  task conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A wait that runs out ends the run at once
  task bound(input int n, input int lim);
    if (n >= lim) begin
      n_fail++;
      $display("BAD %0t wait ran out", $time);
      conclude();
    end
  endtask
  task wcyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Ready lines are always high, so the answer is taken at its first edge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50 && !(awready && wready); n++) @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    for (; n < 50 && !bvalid; n++) @(posedge clk);
    bound(n, 50);
    chk(bresp, er);
  endtask
  // Read that checks the response code and leaves the data in got
  task rdv(input logic [7:0] a, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50 && !arready; n++) @(posedge clk);
    arvalid <= 1'b0;
    for (; n < 50 && !rvalid; n++) @(posedge clk);
    bound(n, 50);
    got = rdata;
    chk(rresp, er);
  endtask
  // Full read: response code, then the whole data word
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    rdv(a, er);
    chk(got, exp);
  endtask
  // ============================================================
  // Scenarios
  task s_reset;
    rd(8'h04, 32'h0000_1770, 2'b00);
    rd(8'h08, 32'h0000_0002, 2'b00);
    rd(8'h0C, 32'h0000_0708, 2'b00);
    rd(8'h20, 32'h0000_0000, 2'b00);
    rd(8'h1C, 32'h0000_0000, 2'b00);
    rd(8'h30, 32'h0000_0000, 2'b10);
    wr(8'h20, 32'h0000_1234, 2'b10);
  endtask
  // Heavy current while the model is off: no model value may build up early
  task s_idle;
    cur_ma <= 16'h2EE0;
    wcyc(20 * TICK);
    rd(8'h20, 32'h0000_0000, 2'b00);
    rd(8'h1C, 32'h0000_0000, 2'b00);
  endtask
  // Twice rated current: 25 percent of target hit near 288 ticks
  task s_model;
    int t;
    wr(8'h0C, 32'h0000_0001, 2'b00);
    wr(8'h00, 32'h0000_0001, 2'b00);
    for (t = 0; t < 400 * TICK && warn_q !== 1'b1; t++) @(posedge clk);
    chk(32'(t / TICK >= 219 && t / TICK <= 230), 1);
    for (; t < 400 * TICK && err_code_q !== 8'h1E; t++) @(posedge clk);
    bound(t, 400 * TICK);
    chk(32'(t / TICK >= 284 && t / TICK <= 296), 1);
    chk(motor_off_q, 1);
    rd(8'h1C, 32'h0001_1E0C, 2'b00);
    rdv(8'h20, 2'b00);
    chk(32'(got >= 10000 && got < 10100), 1);
    cur_ma <= 16'h0000;
    wr(8'h00, 32'h0000_0000, 2'b00);
    wr(8'h1C, 32'h0000_001F, 2'b00);
    rd(8'h1C, 32'h0000_0000, 2'b00);
    chk(err_code_q, 0);
  endtask
  // Linear sensor levels, then pass/fail modes that ignore the reading
  task s_temp;
    int m;
    deg_c <= 16'h0082;
    wcyc(8);
    rd(8'h24, 32'h0000_0082, 2'b00);
    chk(warn_q, 1);
    rd(8'h1C, 32'h0000_0001, 2'b00);
    deg_c <= 16'h0096;
    wcyc(8);
    rd(8'h1C, 32'h0001_0003, 2'b00);
    for (m = 1; m <= 2; m++) begin
      wr(8'h00, 32'(m * 2), 2'b00);
      wcyc(8);
      wr(8'h1C, 32'h0000_0003, 2'b00);
      rd(8'h1C, 32'h0000_0000, 2'b00);
      hot <= 1'b1;
      wcyc(8);
      wr(8'h1C, 32'h0000_0002, 2'b00);
      rd(8'h1C, 32'h0001_0002, 2'b00);
      hot <= 1'b0;
      wcyc(8);
      wr(8'h1C, 32'h0000_0002, 2'b00);
      rd(8'h1C, 32'h0000_0000, 2'b00);
    end
  endtask
  // Drain the overload sum with a huge rating, then trip it with a tiny one
  task s_ovl;
    int t;
    wr(8'h04, 32'h0000_FFFF, 2'b00);
    wcyc(12 * TICK);
    wr(8'h04, 32'h0000_0001, 2'b00);
    rd(8'h1C, 32'h0000_0000, 2'b00);
    cur_ma <= 16'hFFFF;
    for (t = 0; t < 3 * TICK && err_code_q !== 8'h1F; t++) @(posedge clk);
    bound(t, 3 * TICK);
    chk(32'(t <= TICK + 4), 1);
    chk(motor_off_q, 1);
    rd(8'h1C, 32'h0001_1F10, 2'b00);
    cur_ma <= 16'h0000;
    wr(8'h04, 32'h0000_1770, 2'b00);
    wr(8'h1C, 32'h0000_0010, 2'b00);
    rd(8'h1C, 32'h0000_0000, 2'b00);
  endtask
  // ============================================================
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst_b, awvalid, wvalid, arvalid, hot} = 5'h00;
    {awaddr, araddr, wdata, cur_ma} = 64'h0;
    deg_c = 16'h0019;
    n_fail = 0;
    n_compared = 0;
    wcyc(2);
    rst_b <= 1'b1;
    wcyc(1);
    s_reset();
    s_idle();
    s_model();
    s_temp();
    s_ovl();
    conclude();
  end
endmodule // mop_top_test
